/* rss_pkg.sv */
package rss_pkg;
    // Slow clock rate and the power-on pulse length in its own unit.
    localparam int RSS_SLOW_HZ = 32000;
    localparam int RSS_POR_MS = 300;
    // Power-on pulse length in slow clock cycles.
    localparam int RSS_POR_TICKS = (RSS_POR_MS * RSS_SLOW_HZ) / 1000;
    // Stretch and qualify lengths, all in slow clock cycles.
    localparam int RSS_SDRAM_TICKS = 7;
    localparam int RSS_SYS_TICKS = 14;
    localparam int RSS_QUAL_TICKS = 4;
    // Every reset output is asserted while reset_n is low.
    localparam logic RSS_ACTIVE_RST = 1'h1;
    // The slow clock is taken as high coming out of reset, so a level that
    // is already high at release is never mistaken for a fresh rising edge.
    // At worst one tick is lost, which lengthens a stretch, never shortens.
    localparam logic RSS_SLOW_RST = 1'h1;
endpackage : rss_pkg

/* rss_tick_if.sv */
// Carries the one-cycle slow clock tick to the stretch counters.
interface rss_tick_if;
    logic tick;
    modport drive (output tick);
    modport take (input tick);
endinterface : rss_tick_if

/* rss_stretch.sv */
// Holds active while hold is high and for TICKS slow ticks after it drops.
module rss_stretch
    import rss_pkg::*;
#(
    parameter int TICKS = 7
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    rss_tick_if.take tick_if,
    input wire logic hold,
    output logic active
);
    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] FULL = CW'(TICKS);

    generate
        if (TICKS < 1) begin : g_bad
            $error("rss_stretch needs at least one tick");
        end
    endgenerate

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic active_q;
    logic active_d;

    // Reload while held, then count ticks down to release.
    always_comb begin
        cnt_d = cnt_q;
        if (hold) begin
            cnt_d = FULL;
        end else if (tick_if.tick && cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end
        active_d = hold || (cnt_d != '0);
    end

    // Coming out of reset the full stretch is still owed.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= FULL;
            active_q <= RSS_ACTIVE_RST;
        end else begin
            cnt_q <= cnt_d;
            active_q <= active_d;
        end
    end

    assign active = active_q;

    // Helper counts ticks seen since hold last dropped, saturating.
    logic [CW:0] seen_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            seen_q <= '0;
        end else if (hold) begin
            seen_q <= '0;
        end else if (tick_if.tick && seen_q <= {1'h0, FULL}) begin
            seen_q <= seen_q + (CW + 1)'(1);
        end
    end

    a_stretch_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(active_q) |-> (seen_q == {1'h0, FULL}))
    else $error("Stretch released after the wrong tick count.");
endmodule : rss_stretch

/* rss_top.sv */
// Reset sequencer: power-on pulse, hard reset qualifier and two stretchers.
module rss_top
    import rss_pkg::*;
#(
    parameter int POR_TICKS = RSS_POR_TICKS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic slow_32k_clock,
    input wire logic power_on_reset_in_n,
    input wire logic hard_reset_in_n,
    output logic internal_power_on_reset,
    output logic sdram_reset_n,
    output logic internal_bus_system_reset,
    output logic reset_out_n
);
    localparam int QW = $clog2(RSS_QUAL_TICKS + 1);
    localparam logic [QW-1:0] QUAL_FULL = QW'(RSS_QUAL_TICKS);
    localparam logic [QW-1:0] QUAL_LAST = QW'(RSS_QUAL_TICKS - 1);

    generate
        if (POR_TICKS < 1) begin : g_bad_por
            $error("POR_TICKS must be at least one");
        end
    endgenerate

    rss_tick_if tick_bus ();

    // Rising edge of the sampled slow clock makes one tick per slow cycle.
    logic slow_q;
    logic slow_d;
    always_comb begin
        slow_d = slow_32k_clock;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            slow_q <= RSS_SLOW_RST;
        end else begin
            slow_q <= slow_d;
        end
    end
    assign tick_bus.tick = slow_32k_clock && !slow_q;

    // Qualifier: the input must stay low across four ticks in a row.
    // A shorter low is a glitch and resets the count without effect.
    logic [QW-1:0] qual_cnt_q;
    logic [QW-1:0] qual_cnt_d;
    logic hr_qual_q;
    logic hr_qual_d;
    always_comb begin
        qual_cnt_d = qual_cnt_q;
        if (hard_reset_in_n) begin
            qual_cnt_d = '0;
        end else if (tick_bus.tick && qual_cnt_q != QUAL_FULL) begin
            qual_cnt_d = qual_cnt_q + QW'(1);
        end
        hr_qual_d = !hard_reset_in_n && (qual_cnt_d == QUAL_FULL);
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            qual_cnt_q <= '0;
            hr_qual_q <= 1'h0;
        end else begin
            qual_cnt_q <= qual_cnt_d;
            hr_qual_q <= hr_qual_d;
        end
    end

    // Internal power-on pulse runs on after the external input releases.
    logic por_act;
    rss_stretch #(.TICKS(POR_TICKS)) u_por (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick_if (tick_bus),
        .hold (!power_on_reset_in_n),
        .active (por_act)
    );

    // Both downstream resets start from the same cause; the shorter
    // SDRAM stretch lets memory come up before the bus masters run.
    logic src_hold;
    logic sdram_act;
    logic sys_act;
    assign src_hold = por_act || hr_qual_q;

    rss_stretch #(.TICKS(RSS_SDRAM_TICKS)) u_sdram (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick_if (tick_bus),
        .hold (src_hold),
        .active (sdram_act)
    );

    rss_stretch #(.TICKS(RSS_SYS_TICKS)) u_sys (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick_if (tick_bus),
        .hold (src_hold),
        .active (sys_act)
    );

    // Outputs come straight from the stretcher flip-flops.
    assign internal_power_on_reset = por_act;
    assign sdram_reset_n = !sdram_act;
    assign internal_bus_system_reset = sys_act;
    assign reset_out_n = !sys_act;

    sequence s_qual_armed;
        tick_bus.tick && !hard_reset_in_n && (qual_cnt_q == QUAL_LAST);
    endsequence

    a_qual_cause: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(hr_qual_q) |-> $past(tick_bus.tick && !hard_reset_in_n
                                   && qual_cnt_q == QUAL_LAST))
    else $error("Hard reset qualified without four low ticks.");

    a_qual_fires: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_qual_armed |=> hr_qual_q)
    else $error("Fourth low tick did not qualify the hard reset.");

    a_qual_drop: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        hard_reset_in_n |=> !hr_qual_q)
    else $error("Qualified hard reset outlived its input.");

    a_sdram_first: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(sys_act) |-> !sdram_act)
    else $error("System reset released before the SDRAM reset.");

    a_reset_nesting: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        sdram_act |-> (sys_act && !reset_out_n))
    else $error("SDRAM reset held while the system reset is free.");

    a_por_feeds: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        por_act |=> (sdram_act && sys_act))
    else $error("Power-on pulse did not hold the stretched resets.");

    // Checking aid: slow ticks since the stretchers' cause last dropped,
    // and since the external power-on input last went high. Each count
    // saturates one past the longest length that it confirms, so a
    // release that comes much too late still reads as a wrong count.
    localparam int RW = $clog2(RSS_SYS_TICKS + 2);
    localparam int PW = $clog2(POR_TICKS + 2);
    localparam logic [RW-1:0] REL_SDRAM = RW'(RSS_SDRAM_TICKS);
    localparam logic [RW-1:0] REL_SYS = RW'(RSS_SYS_TICKS);
    localparam logic [RW-1:0] REL_CAP = RW'(RSS_SYS_TICKS + 1);
    localparam logic [PW-1:0] POR_FULL = PW'(POR_TICKS);
    localparam logic [PW-1:0] POR_CAP = PW'(POR_TICKS + 1);

    logic [RW-1:0] rel_cnt_q;
    logic [RW-1:0] rel_cnt_d;
    logic [PW-1:0] por_cnt_q;
    logic [PW-1:0] por_cnt_d;

    // Both counts clear while their cause stands and step on each tick.
    always_comb begin
        rel_cnt_d = rel_cnt_q;
        if (src_hold) begin
            rel_cnt_d = '0;
        end else if (tick_bus.tick && rel_cnt_q != REL_CAP) begin
            rel_cnt_d = rel_cnt_q + RW'(1);
        end
        por_cnt_d = por_cnt_q;
        if (!power_on_reset_in_n) begin
            por_cnt_d = '0;
        end else if (tick_bus.tick && por_cnt_q != POR_CAP) begin
            por_cnt_d = por_cnt_q + PW'(1);
        end
    end

    // Starting from zero matches the full counts owed after reset.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rel_cnt_q <= '0;
            por_cnt_q <= '0;
        end else begin
            rel_cnt_q <= rel_cnt_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    // Releases seen at the outputs, each the end of a counted stretch.
    sequence s_por_freed;
        $fell(internal_power_on_reset);
    endsequence

    sequence s_sdram_freed;
        $rose(sdram_reset_n);
    endsequence

    sequence s_sys_freed;
        $fell(internal_bus_system_reset);
    endsequence

    sequence s_pin_freed;
        $rose(reset_out_n);
    endsequence

    a_por_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_por_freed |-> (por_cnt_q == POR_FULL))
    else $error("Power-on pulse ended after the wrong tick count.");

    a_sdram_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_sdram_freed |-> (rel_cnt_q == REL_SDRAM))
    else $error("SDRAM reset released after the wrong tick count.");

    a_sys_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_sys_freed |-> (rel_cnt_q == REL_SYS))
    else $error("System reset released after the wrong tick count.");

    a_pin_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        s_pin_freed |-> (rel_cnt_q == REL_SYS))
    else $error("Reset pin released after the wrong tick count.");

    a_hard_holds: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        hr_qual_q |=> (sdram_act && sys_act))
    else $error("Qualified hard reset did not hold the stretched resets.");
endmodule : rss_top

/* rss_board_model.sv */
// Board reset source: free-running slow crystal plus two reset switches.
module rss_board_model (
    input wire logic por_req,
    input wire logic hard_req,
    output logic slow_32k_clock,
    output logic power_on_reset_in_n,
    output logic hard_reset_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // The crystal runs free, scaled to 20 system cycles per slow period.
    initial begin
        slow_32k_clock = 1'h0;
        forever #40 slow_32k_clock = ~slow_32k_clock;
    end
    // Both reset lines are pulled low while a request is held.
    assign power_on_reset_in_n = ~por_req;
    assign hard_reset_in_n = ~hard_req;
endmodule : rss_board_model

/* tb_reset_stretch_sequencer.sv */
module tb_reset_stretch_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, por_req, hard_req, slow_32k_clock;
    logic por_in_n, hard_in_n, por_q, sdram_n, sys_rst, out_n;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    rss_board_model board (.por_req(por_req), .hard_req(hard_req),
        .slow_32k_clock(slow_32k_clock), .power_on_reset_in_n(por_in_n),
        .hard_reset_in_n(hard_in_n));
    rss_top #(.POR_TICKS(20)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .slow_32k_clock(slow_32k_clock), .power_on_reset_in_n(por_in_n),
        .hard_reset_in_n(hard_in_n), .internal_power_on_reset(por_q),
        .sdram_reset_n(sdram_n), .internal_bus_system_reset(sys_rst),
        .reset_out_n(out_n));
    // System clock at 250 MHz.
    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // A hang is cut short well beyond the expected 2016 cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %b", $time, what, got);
        end
    endtask : chk
    // Sample six cycles after a slow rise, leaving room for a synchroniser.
    task automatic tw(input int n);
        repeat (n) @(posedge slow_32k_clock);
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : tw
    // Downstream releases once their cause has dropped.
    task automatic stretch_check();
        tw(6);
        chk(sdram_n, 1'h0, "sdram early");
        tw(1);
        chk(sdram_n, 1'h1, "sdram late");
        chk(sys_rst, 1'h1, "sys before sdram");
        tw(6);
        chk(sys_rst, 1'h1, "sys early");
        chk(out_n, 1'h0, "pin early");
        tw(1);
        chk(sys_rst, 1'h0, "sys late");
        chk(out_n, 1'h1, "pin late");
    endtask : stretch_check
    task automatic test_por();
        tw(2);
        por_req = 1'h0;
        tw(19);
        chk(por_q, 1'h1, "por early");
        tw(1);
        chk(por_q, 1'h0, "por late");
        chk(sdram_n, 1'h0, "sdram held");
        stretch_check();
    endtask : test_por
    // Three low ticks must be rejected without any reset appearing.
    task automatic test_glitch();
        hard_req = 1'h1;
        tw(3);
        chk(sdram_n, 1'h1, "glitch sdram");
        hard_req = 1'h0;
        tw(8);
        chk(sdram_n, 1'h1, "glitch sdram after");
        chk(sys_rst, 1'h0, "glitch sys");
    endtask : test_glitch
    task automatic test_hard();
        hard_req = 1'h1;
        tw(3);
        chk(sdram_n, 1'h1, "qual early");
        tw(1);
        chk(sdram_n, 1'h0, "qual sdram");
        chk(sys_rst, 1'h1, "qual sys");
        tw(2);
        hard_req = 1'h0;
        stretch_check();
    endtask : test_hard
    // Reset holds every output asserted for two cycles, then lets go.
    task automatic test_reset();
        reset_n = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(por_q, 1'h1, "reset por");
        chk(sdram_n, 1'h0, "reset sdram");
        chk(sys_rst, 1'h1, "reset sys");
        chk(out_n, 1'h0, "reset pin");
        reset_n = 1'h1;
    endtask : test_reset
    // A reset in mid-run, released while the slow clock is high, owes the
    // whole power-on pulse again and must not count a tick for free.
    task automatic test_rerun();
        test_reset();
        tw(19);
        chk(por_q, 1'h1, "rerun por early");
        tw(1);
        chk(por_q, 1'h0, "rerun por late");
        chk(sdram_n, 1'h0, "rerun sdram held");
        stretch_check();
    endtask : test_rerun
    initial begin
        por_req = 1'h1;
        hard_req = 1'h0;
        test_reset();
        test_por();
        test_glitch();
        test_hard();
        test_rerun();
        tally_and_finish();
    end
endmodule : tb_reset_stretch_sequencer
